/* File: design/status_bank_pkg.sv */
// shared constants and types for the charger and regulator status bank
package status_bank_pkg;
    // register map
    localparam logic [7:0] ADDR_DETAIL = 8'h1A;
    localparam logic [7:0] ADDR_TEMP_TIMER = 8'h1B;
    localparam logic [7:0] ADDR_RSVD_FIRST = 8'h1C;
    localparam logic [7:0] ADDR_RSVD_LAST = 8'h1F;
    localparam logic [7:0] ADDR_REG_GOOD = 8'h20;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    // detail status fields
    localparam int BAT_COND_LSB = 4;
    localparam int CHG_STATE_LSB = 0;
    localparam logic [2:0] BAT_COND_RESET = 3'h7;
    localparam logic [2:0] CHG_STATE_RESET = 3'h0;

    // temperature and timer fields
    localparam int TEMP_SUM_BIT = 7;
    localparam int TEMP_ZONE_LSB = 4;
    localparam int DIE_REG_BIT = 2;
    localparam int SAFETY_LSB = 0;
    localparam logic [2:0] TEMP_ZONE_NOMINAL = 3'h0;
    localparam logic [2:0] TEMP_ZONE_RESET = 3'h0;
    localparam logic [1:0] SAFETY_RESET = 2'h0;

    // regulator power good fields
    localparam int CORE_BUCK_BIT = 7;
    localparam int SYSTEM_BUCK_BIT = 6;
    localparam int AON_LINEAR_BIT = 5;
    localparam int SYSTEM_LINEAR_BIT = 4;

    // input power code that means all input checks pass
    localparam logic [1:0] INPUT_POWER_VALID = 2'h3;

    // serial link
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] LAST_BIT = 4'h7;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_PTR,
        ST_PTR_ACK,
        ST_WDATA,
        ST_WDATA_ACK,
        ST_RDATA,
        ST_RACK,
        ST_WAIT_STOP
    } link_state_type;
endpackage

/* File: design/line_sampler.sv */
// registers the two serial lines and flags clock edges, start and stop
`timescale 1ns/1ps
module line_sampler (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_level_out,
    output logic scl_rise_out,
    output logic scl_fall_out,
    output logic start_out,
    output logic stop_out
);
    logic scl_q;
    logic sda_q;
    logic scl_prev_q;
    logic sda_prev_q;

    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
        begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end
        else if (ce_in)
        begin
            scl_q <= scl_in;
            sda_q <= sda_in;
            scl_prev_q <= scl_q;
            sda_prev_q <= sda_q;
        end
    end

    // edge flags one stage later so they line up with sda_level_out
    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
        begin
            sda_level_out <= 1'b1;
            scl_rise_out <= 1'b0;
            scl_fall_out <= 1'b0;
            start_out <= 1'b0;
            stop_out <= 1'b0;
        end
        else if (ce_in)
        begin
            sda_level_out <= sda_q;
            scl_rise_out <= scl_q & ~scl_prev_q;
            scl_fall_out <= ~scl_q & scl_prev_q;
            start_out <= scl_q & scl_prev_q & sda_prev_q & ~sda_q;
            stop_out <= scl_q & scl_prev_q & ~sda_prev_q & sda_q;
        end
    end
endmodule

/* File: design/charger_status_capture.sv */
// captures charger and regulator status levels into reset-defined flops
`timescale 1ns/1ps
module charger_status_capture (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire logic [2:0] battery_condition_in,
    input wire logic [2:0] charge_state_in,
    input wire logic [2:0] battery_temp_zone_in,
    input wire logic thermal_reg_active_in,
    input wire logic [1:0] safety_outcome_in,
    input wire logic [3:0] rail_good_in,
    input wire logic [1:0] input_power_code_in,
    input wire logic input_current_limited_in,
    output logic [2:0] battery_condition_out,
    output logic [2:0] charge_state_out,
    output logic [2:0] battery_temp_zone_out,
    output logic thermal_reg_active_out,
    output logic [1:0] safety_outcome_out,
    output logic [3:0] rail_good_out,
    output logic detail_valid_out
);
    import status_bank_pkg::*;

    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
        begin
            battery_condition_out <= BAT_COND_RESET; // [R2]
            charge_state_out <= CHG_STATE_RESET; // [R3]
            battery_temp_zone_out <= TEMP_ZONE_RESET; // [R6]
            thermal_reg_active_out <= 1'b0; // [R7]
            safety_outcome_out <= SAFETY_RESET; // [R8]
            rail_good_out <= 4'h0; // [R14]
        end
        else if (ce_in)
        begin
            battery_condition_out <= battery_condition_in; // [R2]
            // both fast-charge codes pass unchanged
            charge_state_out <= charge_state_in; // [R3] [R4]
            battery_temp_zone_out <= battery_temp_zone_in; // [R6]
            thermal_reg_active_out <= thermal_reg_active_in; // [R7]
            safety_outcome_out <= safety_outcome_in; // [R8]
            rail_good_out <= rail_good_in; // [R10] [R11] [R12] [R13]
        end
    end

    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
            detail_valid_out <= 1'b0;
        else if (ce_in)
            detail_valid_out <= (input_power_code_in == INPUT_POWER_VALID) // [R15]
                && !input_current_limited_in; // [R1]
    end
endmodule

/* File: design/charger_regulator_status_bank.sv */
// two-wire slave exposing the read-only charger and regulator status bytes
`timescale 1ns/1ps
// How it works
// [R1] detail register is read-only; valid only with input power good and no current limit
// [R2] battery condition bits 6:4, eight codes, resets to 111
// [R3] charge state bits 2:0, idle through done, resets to 000
// [R4] fast charge shows as 011 or 100; 111 is reserved
// [R5] temperature summary bit 7 is 0 only when temperature zone is 000
// [R6] temperature zone bits 6:4: nominal, cold, cool, warm, hot; resets 000
// [R7] bit 2 shows die thermal regulation active; resets 0
// [R8] safety outcome bits 1:0: none, prequal, fast timeout, short test fail
// [R9] addresses 1C to 1F are reserved with no defined status
// [R10] regulator bit 7: core buck output inside its good window
// [R11] regulator bit 6: system buck output inside its good window
// [R12] regulator bit 5: always-on linear regulator inside its good window
// [R13] regulator bit 4: system linear regulator inside its good window
// [R14] regulator register read-only, flags reset 0, low nibble reads 0
// [R15] input power good only when the input power code is 11
// [R16] host writes to these status registers change nothing
module charger_regulator_status_bank #(
    parameter logic [6:0] DEV_ADDR = 7'h2A // arbitrary slave address
) (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out_out,
    output logic sda_oe_out,
    input wire logic [2:0] battery_condition_in,
    input wire logic [2:0] charge_state_in,
    input wire logic [2:0] battery_temp_zone_in,
    input wire logic thermal_reg_active_in,
    input wire logic [1:0] safety_outcome_in,
    input wire logic core_buck_good_in,
    input wire logic system_buck_good_in,
    input wire logic aon_linear_good_in,
    input wire logic system_linear_good_in,
    input wire logic [1:0] input_power_code_in,
    input wire logic input_current_limited_in,
    output logic detail_valid_out
);
    import status_bank_pkg::*;

    logic sda_level;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    logic [2:0] battery_condition;
    logic [2:0] charge_state;
    logic [2:0] battery_temp_zone;
    logic thermal_reg_active;
    logic [1:0] safety_outcome;
    logic [3:0] rail_good;
    logic detail_valid;

    link_state_type state_q;
    logic [3:0] bit_cnt_q;
    logic [7:0] shift_q;
    logic [7:0] ptr_q;
    logic rw_q;
    logic [7:0] rd_byte;

    // two-cycle lag from pin to edge flag, the host phases must cover it
    line_sampler u_lines (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .ce_in(ce_in),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .sda_level_out(sda_level),
        .scl_rise_out(scl_rise),
        .scl_fall_out(scl_fall),
        .start_out(start_seen),
        .stop_out(stop_seen)
    );

    charger_status_capture u_status (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .ce_in(ce_in),
        .battery_condition_in(battery_condition_in),
        .charge_state_in(charge_state_in),
        .battery_temp_zone_in(battery_temp_zone_in),
        .thermal_reg_active_in(thermal_reg_active_in),
        .safety_outcome_in(safety_outcome_in),
        .rail_good_in({core_buck_good_in, system_buck_good_in,
                       aon_linear_good_in, system_linear_good_in}),
        .input_power_code_in(input_power_code_in),
        .input_current_limited_in(input_current_limited_in),
        .battery_condition_out(battery_condition),
        .charge_state_out(charge_state),
        .battery_temp_zone_out(battery_temp_zone),
        .thermal_reg_active_out(thermal_reg_active),
        .safety_outcome_out(safety_outcome),
        .rail_good_out(rail_good),
        .detail_valid_out(detail_valid)
    );

    // byte presented to the host for a register address
    function automatic logic [7:0] read_byte(input logic [7:0] addr);
        logic [7:0] value;
        value = READ_UNMAPPED;
        if (addr == ADDR_DETAIL)
        begin
            value[BAT_COND_LSB +: 3] = battery_condition; // [R2]
            value[CHG_STATE_LSB +: 3] = charge_state; // [R3] [R4]
        end
        else if (addr == ADDR_TEMP_TIMER)
        begin
            value[TEMP_SUM_BIT] = (battery_temp_zone != TEMP_ZONE_NOMINAL); // [R5]
            value[TEMP_ZONE_LSB +: 3] = battery_temp_zone; // [R6]
            value[DIE_REG_BIT] = thermal_reg_active; // [R7]
            value[SAFETY_LSB +: 2] = safety_outcome; // [R8]
        end
        else if (addr == ADDR_REG_GOOD)
        begin
            // low nibble stays zero from the default
            value[CORE_BUCK_BIT] = rail_good[3]; // [R10] [R14]
            value[SYSTEM_BUCK_BIT] = rail_good[2]; // [R11]
            value[AON_LINEAR_BIT] = rail_good[1]; // [R12]
            value[SYSTEM_LINEAR_BIT] = rail_good[0]; // [R13]
        end
        // 1C..1F and everything else read as zero
        else if (addr >= ADDR_RSVD_FIRST && addr <= ADDR_RSVD_LAST)
        begin
            value = READ_UNMAPPED; // [R9]
        end
        return value;
    endfunction

    // one decode feeds both places where a read byte is loaded
    always_comb
    begin
        rd_byte = read_byte(ptr_q);
    end

    // validity is only reported, the bytes are never blanked by it
    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
            detail_valid_out <= 1'b0;
        else if (ce_in)
            detail_valid_out <= detail_valid; // [R1] [R15]
    end

    // open-drain line: only ever pulled low
    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
            sda_out_out <= 1'b0;
        else if (ce_in)
            sda_out_out <= 1'b0;
    end

    // link sequencer: sample on scl rise, drive on scl fall
    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
        begin
            state_q <= ST_IDLE;
            bit_cnt_q <= 4'h0;
            shift_q <= 8'h00;
            ptr_q <= 8'h00;
            rw_q <= 1'b0;
            sda_oe_out <= 1'b0;
        end
        else if (ce_in)
        begin
            // a start anywhere restarts address matching
            if (start_seen)
            begin
                state_q <= ST_ADDR;
                bit_cnt_q <= 4'h0;
                sda_oe_out <= 1'b0;
            end
            else if (stop_seen)
            begin
                state_q <= ST_IDLE;
                sda_oe_out <= 1'b0;
            end
            else
            begin
                unique case (state_q)
                    ST_IDLE, ST_WAIT_STOP:
                    begin
                        sda_oe_out <= 1'b0;
                    end
                    ST_ADDR, ST_PTR, ST_WDATA:
                    begin
                        if (scl_rise && bit_cnt_q != BITS_PER_BYTE)
                        begin
                            shift_q <= {shift_q[6:0], sda_level};
                            bit_cnt_q <= bit_cnt_q + 4'h1;
                        end
                        else if (scl_fall && bit_cnt_q == BITS_PER_BYTE)
                        begin
                            bit_cnt_q <= 4'h0;
                            if (state_q == ST_ADDR)
                            begin
                                if (shift_q[7:1] == DEV_ADDR)
                                begin
                                    rw_q <= shift_q[0];
                                    sda_oe_out <= 1'b1;
                                    state_q <= ST_ADDR_ACK;
                                end
                                else
                                begin
                                    // foreign address: stay off the line until stop or a new start
                                    state_q <= ST_WAIT_STOP;
                                end
                            end
                            else if (state_q == ST_PTR)
                            begin
                                ptr_q <= shift_q;
                                sda_oe_out <= 1'b1;
                                state_q <= ST_PTR_ACK;
                            end
                            else
                            begin
                                // data byte acknowledged and dropped
                                sda_oe_out <= 1'b1; // [R16]
                                state_q <= ST_WDATA_ACK;
                            end
                        end
                    end
                    ST_ADDR_ACK:
                    begin
                        if (scl_fall)
                        begin
                            if (rw_q)
                            begin
                                shift_q <= rd_byte;
                                sda_oe_out <= ~rd_byte[7];
                                state_q <= ST_RDATA;
                            end
                            else
                            begin
                                sda_oe_out <= 1'b0;
                                state_q <= ST_PTR;
                            end
                        end
                    end
                    ST_PTR_ACK, ST_WDATA_ACK:
                    begin
                        if (scl_fall)
                        begin
                            sda_oe_out <= 1'b0;
                            state_q <= ST_WDATA; // [R16]
                        end
                    end
                    ST_RDATA:
                    begin
                        if (scl_fall)
                        begin
                            if (bit_cnt_q == LAST_BIT)
                            begin
                                bit_cnt_q <= 4'h0;
                                sda_oe_out <= 1'b0;
                                // pointer wraps past FF, a long burst restarts at 00
                                ptr_q <= ptr_q + 8'h01;
                                state_q <= ST_RACK;
                            end
                            else
                            begin
                                bit_cnt_q <= bit_cnt_q + 4'h1;
                                shift_q <= {shift_q[6:0], 1'b0};
                                sda_oe_out <= ~shift_q[6];
                            end
                        end
                    end
                    ST_RACK:
                    begin
                        // host nack ends the read burst
                        if (scl_rise)
                        begin
                            rw_q <= ~sda_level;
                        end
                        else if (scl_fall)
                        begin
                            if (rw_q)
                            begin
                                shift_q <= rd_byte;
                                sda_oe_out <= ~rd_byte[7];
                                state_q <= ST_RDATA;
                            end
                            else
                            begin
                                state_q <= ST_WAIT_STOP;
                            end
                        end
                    end
                    default:
                    begin
                        state_q <= ST_IDLE;
                        sda_oe_out <= 1'b0;
                    end
                endcase
            end
        end
    end
endmodule

/* File: sim/status_bank_assertions.sv */
// port-level checks for the charger and regulator status bank
`timescale 1ns/1ps
module status_bank_assertions
    import status_bank_pkg::*;
(
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out_out,
    input wire logic sda_oe_out,
    input wire logic [1:0] input_power_code_in,
    input wire logic input_current_limited_in,
    input wire logic detail_valid_out
);
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (rst_in);

    // two running cycles behind us, so the 2-cycle valid pipeline is full
    logic [1:0] live_q;
    always_ff @(posedge mclk_in)
    begin
        live_q <= {live_q[0], ce_in & ~rst_in};
    end

    a_valid_both_ok: assert property (live_q == 2'b11
        && !$past(input_current_limited_in, 2)
        && $past(input_power_code_in, 2) == INPUT_POWER_VALID |-> detail_valid_out)
        else $error("detail valid low with good power and no limit");
    a_valid_code_bad: assert property (live_q == 2'b11
        && $past(input_power_code_in, 2) != INPUT_POWER_VALID |-> !detail_valid_out)
        else $error("detail valid high with bad input power code");
    a_valid_limit_off: assert property (live_q == 2'b11
        && $past(input_current_limited_in, 2) |-> !detail_valid_out)
        else $error("detail valid high during current limit");
    a_valid_frozen_ce: assert property (!ce_in |=> $stable(detail_valid_out))
        else $error("detail valid moved while clock enable low");
    a_reset_all_clear: assert property ($past(rst_in) |-> !detail_valid_out && !sda_oe_out)
        else $error("outputs not cleared by reset");
    a_oe_scl_low: assert property ($changed(sda_oe_out) |-> !scl_in)
        else $error("data drive changed while serial clock high");
    a_start_no_drive: assert property (scl_in && $past(scl_in) && $fell(sda_in)
        |-> ##1 (!sda_oe_out) [*8])
        else $error("data driven right after start");
    a_stop_release: assert property (scl_in && $past(scl_in) && $rose(sda_in)
        |-> ##[1:6] !sda_oe_out)
        else $error("data still driven after stop");
    a_data_open_drain: assert property (sda_out_out == 1'b0)
        else $error("data output value not low");
endmodule

bind charger_regulator_status_bank status_bank_assertions i_status_bank_assertions (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sda_out_out(sda_out_out),
    .sda_oe_out(sda_oe_out),
    .input_power_code_in(input_power_code_in),
    .input_current_limited_in(input_current_limited_in),
    .detail_valid_out(detail_valid_out)
);

/* File: sim/host_link_model.sv */
// two-wire host that clocks the bus and pulls data low
`timescale 1ns/1ps
module host_link_model (
    input wire logic mclk_in,
    input wire logic sda_in,
    output logic scl_out,
    output logic sda_low_out
);
    initial
    begin
        scl_out = 1'b1;
        sda_low_out = 1'b0;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk_in);
    endtask

    // 8 cycles per clock phase leaves room for the slave's 3-cycle answer lag
    task automatic put_bit(input logic b);
        sda_low_out <= ~b;
        cyc(4);
        scl_out <= 1'b1;
        cyc(8);
        scl_out <= 1'b0;
        cyc(4);
    endtask

    task automatic get_bit(output logic b);
        sda_low_out <= 1'b0;
        cyc(4);
        scl_out <= 1'b1;
        cyc(4);
        b = sda_in;
        cyc(4);
        scl_out <= 1'b0;
        cyc(4);
    endtask

    // also serves as repeated start from a low clock
    task automatic start;
        sda_low_out <= 1'b0;
        cyc(4);
        scl_out <= 1'b1;
        cyc(8);
        sda_low_out <= 1'b1;
        cyc(8);
        scl_out <= 1'b0;
        cyc(4);
    endtask

    task automatic stop;
        sda_low_out <= 1'b1;
        cyc(4);
        scl_out <= 1'b1;
        cyc(8);
        sda_low_out <= 1'b0;
        cyc(8);
    endtask

    task automatic write_byte(input logic [7:0] v, output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--)
            put_bit(v[i]);
        get_bit(b);
        ack = ~b;
    endtask

    task automatic read_byte(input logic nack, output logic [7:0] v);
        logic b;
        for (int i = 7; i >= 0; i--)
        begin
            get_bit(b);
            v[i] = b;
        end
        put_bit(nack);
    endtask

    task automatic read_reg(input logic [6:0] dev, input logic [7:0] ptr,
                            output logic [7:0] v, output logic ok);
        logic a0, a1, a2;
        start();
        write_byte({dev, 1'b0}, a0);
        write_byte(ptr, a1);
        start();
        write_byte({dev, 1'b1}, a2);
        read_byte(1'b1, v);
        stop();
        ok = a0 & a1 & a2;
    endtask

    task automatic write_reg(input logic [6:0] dev, input logic [7:0] ptr,
                             input logic [7:0] v, output logic ok);
        logic a0, a1, a2;
        start();
        write_byte({dev, 1'b0}, a0);
        write_byte(ptr, a1);
        write_byte(v, a2);
        stop();
        ok = a0 & a1 & a2;
    endtask
endmodule

/* File: sim/charger_regulator_status_bank_tb.sv */
// self-checking bench for the charger and regulator status bank
`timescale 1ns/1ps
`define check_eq(what, exp, got) \
    begin \
        checks++; \
        if ((got) !== (exp)) \
        begin \
            miscompares++; \
            $display("BAD %s expected %h seen %h", what, exp, got); \
        end \
    end
module charger_regulator_status_bank_tb;
    import status_bank_pkg::*;
    localparam logic [6:0] DEVICE_ADDR = 7'h2A;
    logic mclk_in = 1'b0;
    logic rst_in = 1'b1;
    logic ce_in = 1'b1;
    logic [2:0] cond = 3'h7;
    logic [2:0] chg = 3'h0;
    logic [2:0] zone = 3'h0;
    logic thermal = 1'b0;
    logic [1:0] safety = 2'h0;
    logic core, sysb, aon, sysl;
    logic [1:0] pwr = 2'h0;
    logic ilim = 1'b0;
    logic scl, host_low, sda_oe, sda_out, sda, detail_valid;
    int checks = 0;
    int miscompares = 0;
    int cycles = 0;

    initial {core, sysb, aon, sysl} = 4'h0;
    // pull-up on the data wire
    assign sda = ~(host_low | (sda_oe & ~sda_out));
    always #4 mclk_in = ~mclk_in;

    charger_regulator_status_bank #(.DEV_ADDR(DEVICE_ADDR)) i_charger_regulator_status_bank (
        .mclk_in(mclk_in), .rst_in(rst_in), .ce_in(ce_in), .scl_in(scl), .sda_in(sda),
        .sda_out_out(sda_out), .sda_oe_out(sda_oe), .battery_condition_in(cond),
        .charge_state_in(chg), .battery_temp_zone_in(zone), .thermal_reg_active_in(thermal),
        .safety_outcome_in(safety), .core_buck_good_in(core), .system_buck_good_in(sysb),
        .aon_linear_good_in(aon), .system_linear_good_in(sysl), .input_power_code_in(pwr),
        .input_current_limited_in(ilim), .detail_valid_out(detail_valid));

    host_link_model i_host_link_model (.mclk_in(mclk_in), .sda_in(sda), .scl_out(scl),
        .sda_low_out(host_low));

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk_in);
    endtask

    task automatic test_done;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic expect_reg(input logic [7:0] ptr, input logic [7:0] exp);
        logic [7:0] v;
        logic ok;
        i_host_link_model.read_reg(DEVICE_ADDR, ptr, v, ok);
        `check_eq("read ack", 1'b1, ok)
        `check_eq("status byte", exp, v)
    endtask

    task automatic t_reset_values;
        expect_reg(ADDR_DETAIL, 8'h70);
        expect_reg(ADDR_TEMP_TIMER, 8'h00);
        expect_reg(ADDR_REG_GOOD, 8'h00);
    endtask

    task automatic t_detail_codes;
        for (int i = 0; i < 8; i++)
        begin
            cond <= 3'(i);
            chg <= 3'(7 - i);
            expect_reg(ADDR_DETAIL, {1'b0, 3'(i), 1'b0, 3'(7 - i)});
        end
    endtask

    task automatic t_temp_codes;
        for (int i = 0; i < 8; i++)
        begin
            zone <= 3'(i);
            thermal <= i[0];
            safety <= 2'(i >> 1);
            expect_reg(ADDR_TEMP_TIMER,
                {i != 0, 3'(i), 1'b0, i[0], 2'(i >> 1)});
        end
    endtask

    task automatic t_rails;
        for (int i = 0; i < 16; i++)
        begin
            {core, sysb, aon, sysl} <= 4'(i);
            expect_reg(ADDR_REG_GOOD, {4'(i), 4'h0});
        end
    endtask

    task automatic t_reserved;
        for (int p = 8'h1C; p <= 8'h1F; p++)
            expect_reg(8'(p), READ_UNMAPPED);
        expect_reg(8'h21, READ_UNMAPPED);
    endtask

    task automatic t_writes;
        logic ok;
        cond <= 3'h5;
        chg <= 3'h3;
        zone <= 3'h4;
        thermal <= 1'b1;
        safety <= 2'h2;
        {core, sysb, aon, sysl} <= 4'hA;
        i_host_link_model.write_reg(DEVICE_ADDR, ADDR_DETAIL, 8'hFF, ok);
        `check_eq("write ack", 1'b1, ok)
        i_host_link_model.write_reg(DEVICE_ADDR, ADDR_TEMP_TIMER, 8'h00, ok);
        `check_eq("write ack", 1'b1, ok)
        i_host_link_model.write_reg(DEVICE_ADDR, ADDR_REG_GOOD, 8'h5F, ok);
        `check_eq("write ack", 1'b1, ok)
        expect_reg(ADDR_DETAIL, 8'h53);
        expect_reg(ADDR_TEMP_TIMER, 8'hC6);
        expect_reg(ADDR_REG_GOOD, 8'hA0);
        i_host_link_model.write_reg(DEVICE_ADDR + 7'h1, ADDR_DETAIL, 8'h00, ok);
        `check_eq("foreign address ack", 1'b0, ok)
    endtask

    // host acks the first byte, so a second byte is read from the next register
    task automatic t_burst;
        logic [7:0] v0, v1;
        logic a0, a1, a2;
        i_host_link_model.start();
        i_host_link_model.write_byte({DEVICE_ADDR, 1'b0}, a0);
        i_host_link_model.write_byte(ADDR_DETAIL, a1);
        i_host_link_model.start();
        i_host_link_model.write_byte({DEVICE_ADDR, 1'b1}, a2);
        i_host_link_model.read_byte(1'b0, v0);
        i_host_link_model.read_byte(1'b1, v1);
        i_host_link_model.stop();
        `check_eq("burst ack", 1'b1, a0 & a1 & a2)
        `check_eq("burst first", 8'h53, v0)
        `check_eq("burst second", 8'hC6, v1)
    endtask

    task automatic t_valid;
        for (int i = 0; i < 8; i++)
        begin
            pwr <= 2'(i);
            ilim <= i[2];
            cyc(4);
            `check_eq("detail valid", (i[1:0] == 2'h3) && !i[2], detail_valid)
        end
        pwr <= INPUT_POWER_VALID;
        ilim <= 1'b0;
        cyc(4);
        ce_in <= 1'b0;
        ilim <= 1'b1;
        cyc(4);
        `check_eq("valid frozen", 1'b1, detail_valid)
        ce_in <= 1'b1;
        cyc(4);
        `check_eq("valid after limit", 1'b0, detail_valid)
    endtask

    // whole run needs about 30400 cycles
    always @(posedge mclk_in)
    begin
        cycles++;
        if (cycles == 80000)
        begin
            miscompares++;
            test_done();
        end
    end

    initial
    begin
        cyc(2);
        rst_in <= 1'b0;
        cyc(2);
        t_reset_values();
        t_detail_codes();
        t_temp_codes();
        t_rails();
        t_reserved();
        t_writes();
        t_burst();
        t_valid();
        test_done();
    end
endmodule
